// *** dog_pkg.sv ***
package dog_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_WATCHDOG_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_SYSTEM_CONTROL = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_PORTA_WAKE_ENABLE = 4'h3;
    localparam logic [3:0] ADDR_INT_CONTROL = 4'h4;
    // watchdog_control fields and reset value
    localparam int KEY_MSB = 7;
    localparam int KEY_LSB = 3;
    localparam int SEL_MSB = 2;
    localparam int SEL_LSB = 0;
    localparam logic [4:0] KEY_DISABLE = 5'h15;
    localparam logic [4:0] KEY_ENABLE = 5'h0A;
    localparam logic [7:0] WATCHDOG_CONTROL_RST = 8'h53;
    // system_control fields
    localparam int IDLE_KEEP_BIT = 7;
    localparam int LVR_FLAG_BIT = 2;
    localparam int LV_FAULT_BIT = 1;
    localparam int DOG_FAULT_BIT = 0;
    localparam logic [7:0] SYSTEM_CONTROL_MASK = 8'h87;
    // status fields
    localparam int PD_BIT = 0;
    localparam int TO_BIT = 1;
    localparam int SLEEP_BIT = 2;
    // Counter and delay
    localparam int DOG_CNT_W = 19;
    localparam int SRESET_CYCLES = 16;
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_DOWN = 2'b01,
        PWR_WAKE = 2'b11
    } pwr_state_type;
endpackage : dog_pkg

// *** dog_counter.sv ***
`timescale 1ns/10ps
`default_nettype none
module dog_counter
    import dog_pkg::*;
#(
    parameter int CNT_W = DOG_CNT_W
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Control
    input wire logic run_i,
    input wire logic clear_i,
    input wire logic [2:0] sel_i,
    // Status
    output logic overflow_o,
    output logic [CNT_W-1:0] count_o
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] limit;
    logic [4:0] expo;

    // Period exponents 8,10,12,14,15,16,17,18
    assign expo = (sel_i == 3'h0) ? 5'h08 :
                  (sel_i == 3'h1) ? 5'h0A :
                  (sel_i == 3'h2) ? 5'h0C :
                  (sel_i == 3'h3) ? 5'h0E : 5'(5'h0B + 5'(sel_i));
    assign limit = CNT_W'(1) << expo;
    assign overflow_o = run_i && !clear_i && (cnt_r == limit - CNT_W'(1));
    assign cnt_nxt = (clear_i || overflow_o) ? '0 : (run_i ? cnt_r + CNT_W'(1) : cnt_r);
    assign count_o = cnt_r;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule : dog_counter
`default_nettype wire

// *** edge_wake.sv ***
`timescale 1ns/10ps
`default_nettype none
module edge_wake #(
    parameter int PINS = 8
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Pins and enables
    input wire logic [PINS-1:0] pin_i,
    input wire logic [PINS-1:0] enable_i,
    // Result
    output logic fall_o
);
    logic [PINS-1:0] prev_r;
    logic [PINS-1:0] fell;

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            // Reset to high so a pin low at reset reads as a falling edge in the first cycle after reset
            always_ff @(posedge sys_clk_i) begin
                if (srst_i) begin
                    prev_r[g] <= 1'b1;
                end else begin
                    prev_r[g] <= pin_i[g];
                end
            end
            assign fell[g] = prev_r[g] && !pin_i[g] && enable_i[g];
        end
    endgenerate
    assign fall_o = |fell;
endmodule : edge_wake
`default_nettype wire

// *** watchdog_and_wakeup.sv ***
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module watchdog_and_wakeup
    import dog_pkg::*;
#(
    parameter int PINS = 8,
    parameter int SRESET_DELAY = SRESET_CYCLES
) (
    // Clock and reset; clock is the low-speed source clock
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // CPU core
    input wire logic stop_i,
    input wire logic dog_clear_i,
    input wire logic int_req_i,
    input wire logic int_enabled_i,
    input wire logic stack_full_i,
    // Port A
    input wire logic [PINS-1:0] porta_i,
    // Results
    output logic sleeping_o,
    output logic wake_o,
    output logic wake_vector_o,
    output logic wake_resume_o,
    output logic core_reset_o,
    output logic pc_sp_reset_o
);
    pwr_state_type state_r;
    pwr_state_type state_nxt;
    logic [7:0] wdc_r;
    logic [PINS-1:0] porta_wake_enable_r;
    logic idle_sysclk_keep_r;
    logic lowvolt_reset_flag_r;
    logic lowvolt_ctrl_fault_flag_r;
    logic dog_ctrl_fault_flag_r;
    logic powerdown_flag_r;
    logic timeout_flag_r;
    logic int_armed_r;
    logic [7:0] rdata_r;
    logic [7:0] srst_cnt_r;
    logic pending_r;
    logic core_reset_r;
    logic pc_sp_reset_r;
    logic wake_r;
    logic vector_r;
    logic resume_r;

    logic [4:0] key;
    logic dog_run;
    logic key_bad;
    logic overflow;
    logic port_fall;
    logic asleep;
    logic int_wake;
    logic int_vec;
    logic wake_any;
    logic cnt_clear;
    logic wr_wdc;
    logic wr_sys;
    logic wr_porta_wake_enable;
    logic sreset_fire;
    logic [7:0] sys_rd;
    logic [7:0] status_rd;
    logic [7:0] porta_wake_enable_rd;
    logic [7:0] rd_mux;

    assign key = wdc_r[KEY_MSB:KEY_LSB];
    assign dog_run = (key == KEY_ENABLE);
    assign key_bad = (key != KEY_ENABLE) && (key != KEY_DISABLE);
    assign asleep = (state_r == PWR_DOWN);
    // Only a request raised after entry counts
    assign int_wake = asleep && int_req_i && int_armed_r;
    // Masked or stack-full interrupt resumes instead; the core keeps it pending
    assign int_vec = int_wake && int_enabled_i && !stack_full_i;
    assign wake_any = asleep && (port_fall || int_wake || overflow);
    assign sreset_fire = pending_r && (srst_cnt_r == 8'(SRESET_DELAY - 1));
    assign cnt_clear = dog_clear_i || stop_i || sreset_fire;
    assign wr_wdc = wr_i && (addr_i == ADDR_WATCHDOG_CONTROL);
    assign wr_sys = wr_i && (addr_i == ADDR_SYSTEM_CONTROL);
    assign wr_porta_wake_enable = wr_i && (addr_i == ADDR_PORTA_WAKE_ENABLE);
    assign sys_rd = {idle_sysclk_keep_r, 4'h0, lowvolt_reset_flag_r,
                     lowvolt_ctrl_fault_flag_r, dog_ctrl_fault_flag_r} & SYSTEM_CONTROL_MASK;
    assign status_rd = {5'h00, asleep, timeout_flag_r, powerdown_flag_r};
    assign porta_wake_enable_rd = 8'(porta_wake_enable_r);
    // Unmapped indices read zero so software sees no stale bus value
    assign rd_mux = (addr_i == ADDR_WATCHDOG_CONTROL) ? wdc_r :
                    (addr_i == ADDR_SYSTEM_CONTROL) ? sys_rd :
                    (addr_i == ADDR_STATUS) ? status_rd :
                    (addr_i == ADDR_PORTA_WAKE_ENABLE) ? porta_wake_enable_rd : 8'h00;

    dog_counter #(
        .CNT_W(DOG_CNT_W)
    ) u_counter (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .run_i(dog_run),
        .clear_i(cnt_clear),
        .sel_i(wdc_r[SEL_MSB:SEL_LSB]),
        .overflow_o(overflow),
        .count_o()
    );

    edge_wake #(
        .PINS(PINS)
    ) u_edge (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .pin_i(porta_i),
        .enable_i(porta_wake_enable_r),
        .fall_o(port_fall)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PWR_RUN: begin
                if (stop_i) begin
                    state_nxt = PWR_DOWN;
                end
            end
            PWR_DOWN: begin
                if (wake_any) begin
                    state_nxt = PWR_WAKE;
                end
            end
            PWR_WAKE: state_nxt = PWR_RUN;
            default: state_nxt = PWR_RUN;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_r <= PWR_RUN;
            int_armed_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            // Disarm if the request is already up at entry
            int_armed_r <= asleep ? (int_armed_r || !int_req_i) : !(stop_i && int_req_i);
        end
    end

    // Wake pulses, one cycle after the cause; exactly one kind per wake
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            wake_r <= 1'b0;
            vector_r <= 1'b0;
            resume_r <= 1'b0;
        end else begin
            wake_r <= wake_any;
            vector_r <= int_vec;
            resume_r <= wake_any && !int_vec;
        end
    end

    // Watchdog control register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            wdc_r <= WATCHDOG_CONTROL_RST;
        end else if (wr_wdc) begin
            wdc_r <= wdata_i;
        end
    end

    // Port wake enables, one per pin
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            porta_wake_enable_r <= '0;
        end else if (wr_porta_wake_enable) begin
            porta_wake_enable_r <= wdata_i[PINS-1:0];
        end
    end

    // Low-voltage flags: writing zero clears, writing one keeps
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            idle_sysclk_keep_r <= 1'b0;
            lowvolt_reset_flag_r <= 1'b0;
            lowvolt_ctrl_fault_flag_r <= 1'b0;
        end else if (wr_sys) begin
            idle_sysclk_keep_r <= wdata_i[IDLE_KEEP_BIT];
            lowvolt_reset_flag_r <= lowvolt_reset_flag_r & wdata_i[LVR_FLAG_BIT];
            lowvolt_ctrl_fault_flag_r <= lowvolt_ctrl_fault_flag_r & wdata_i[LV_FAULT_BIT];
        end
    end

    // Read data stand one cycle only, zero otherwise
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rd_i ? rd_mux : 8'h00;
        end
    end

    // Fault flag survives the reset it causes; set beats clear
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            dog_ctrl_fault_flag_r <= 1'b0;
        end else if (sreset_fire) begin
            dog_ctrl_fault_flag_r <= 1'b1;
        end else if (wr_sys && !wdata_i[DOG_FAULT_BIT]) begin
            dog_ctrl_fault_flag_r <= 1'b0;
        end
    end

    // Delayed software reset on a bad key
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pending_r <= 1'b0;
            srst_cnt_r <= 8'h00;
        end else if (sreset_fire || !key_bad) begin
            pending_r <= 1'b0;
            srst_cnt_r <= 8'h00;
        end else begin
            pending_r <= 1'b1;
            srst_cnt_r <= pending_r ? srst_cnt_r + 8'h01 : 8'h00;
        end
    end

    // Power-down flag survives watchdog resets; set beats clear
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            powerdown_flag_r <= 1'b0;
        end else if (stop_i && state_r == PWR_RUN) begin
            powerdown_flag_r <= 1'b1;
        end else if (dog_clear_i) begin
            powerdown_flag_r <= 1'b0;
        end
    end

    // Time-out flag survives watchdog resets; a clear in the same cycle suppresses the overflow
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            timeout_flag_r <= 1'b0;
        end else if (overflow) begin
            timeout_flag_r <= 1'b1;
        end else if (stop_i || dog_clear_i) begin
            timeout_flag_r <= 1'b0;
        end
    end

    // Full reset; not fed back, the system reset tree owns it
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            core_reset_r <= 1'b0;
        end else begin
            core_reset_r <= sreset_fire || (overflow && !asleep);
        end
    end

    // Asleep overflow only restarts program counter and stack
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pc_sp_reset_r <= 1'b0;
        end else begin
            pc_sp_reset_r <= overflow && asleep;
        end
    end

    assign rdata_o = rdata_r;
    assign sleeping_o = asleep;
    assign wake_o = wake_r;
    assign wake_vector_o = vector_r;
    assign wake_resume_o = resume_r;
    assign core_reset_o = core_reset_r;
    assign pc_sp_reset_o = pc_sp_reset_r;
endmodule : watchdog_and_wakeup
`default_nettype wire

// *** cpu_core_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Bench requests
    input wire logic halt_req_i,
    input wire logic clr_req_i,
    input wire logic sleeping_i,
    // Instructions
    output logic stop_o,
    output logic dog_clear_o
);
    // A halted core executes nothing
    always_ff @(posedge sys_clk_i) begin
        stop_o <= !srst_i && halt_req_i && !sleeping_i;
        dog_clear_o <= !srst_i && clr_req_i && !sleeping_i;
    end
endmodule : cpu_core_model
`default_nettype wire

// *** watchdog_and_wakeup_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module watchdog_and_wakeup_sva
    import dog_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Inputs
    input wire logic [3:0] addr_i,
    input wire logic rd_i,
    input wire logic stop_i,
    input wire logic int_req_i,
    input wire logic int_enabled_i,
    input wire logic stack_full_i,
    // Outputs
    input wire logic [7:0] rdata_o,
    input wire logic sleeping_o,
    input wire logic wake_o,
    input wire logic wake_vector_o,
    input wire logic wake_resume_o,
    input wire logic core_reset_o,
    input wire logic pc_sp_reset_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);
    sequence s_halt;
        stop_i && !sleeping_o;
    endsequence
    sequence s_int_rise;
        sleeping_o && $past(sleeping_o) && !wake_o && $rose(int_req_i);
    endsequence
    AST_CTRL_ZERO: assert property ($past(rd_i) && $past(addr_i) == ADDR_SYSTEM_CONTROL |-> rdata_o[6:3] == 4'h0)
        else $error("control bits 6..3 not zero");
    AST_RDATA_QUIET: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    AST_STOP_SLEEPS: assert property (s_halt |=> sleeping_o)
        else $error("stop did not power down");
    AST_WAKE_ASLEEP: assert property (wake_o |-> $past(sleeping_o))
        else $error("wake while running");
    AST_WAKE_RUN: assert property (wake_o |=> !sleeping_o)
        else $error("still asleep after wake");
    AST_WAKE_KIND: assert property (wake_o || wake_vector_o || wake_resume_o |-> wake_o && (wake_vector_o != wake_resume_o))
        else $error("wake kind not exactly one");
    AST_VECTOR_COND: assert property (wake_vector_o |-> $past(int_enabled_i) && !$past(stack_full_i))
        else $error("vector without enabled int and free stack");
    AST_INT_WAKES: assert property (s_int_rise |=> wake_o)
        else $error("fresh interrupt did not wake");
    AST_PCSP: assert property (pc_sp_reset_o |-> wake_o && wake_resume_o && !core_reset_o)
        else $error("partial reset outside sleep wake");
endmodule : watchdog_and_wakeup_sva
`default_nettype wire

// *** test_watchdog_and_wakeup.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin bad_count++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module test_watchdog_and_wakeup
    import dog_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic int_req_i = 1'b0;
    logic int_enabled_i = 1'b1;
    logic stack_full_i = 1'b0;
    logic [7:0] porta_i = 8'hFF;
    logic halt_req = 1'b0;
    logic clr_req = 1'b0;
    logic stop_i, dog_clear_i, sleeping_o, wake_o, wake_vector_o, wake_resume_o, core_reset_o, pc_sp_reset_o;
    logic [7:0] rdata_o;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int nrst = 0;
    int nwake = 0;
    int nvec = 0;
    int nres = 0;
    int npcsp = 0;
    // Short bad-key delay keeps the run brief
    watchdog_and_wakeup #(.PINS(8), .SRESET_DELAY(3)) uut (.*);
    cpu_core_model core (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .halt_req_i(halt_req), .clr_req_i(clr_req),
        .sleeping_i(sleeping_o), .stop_o(stop_i), .dog_clear_o(dog_clear_i));
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (core_reset_o === 1'b1) nrst++;
        if (wake_o === 1'b1) nwake++;
        if (wake_vector_o === 1'b1) nvec++;
        if (wake_resume_o === 1'b1) nres++;
        if (pc_sp_reset_o === 1'b1) npcsp++;
        if (cyc == 6000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        `CHK("rdata", e, rdata_o);
    endtask : rd
    // One halt (h=1) or watchdog clear (h=0) through the core
    task automatic instr(input bit h);
        @(posedge sys_clk_i);
        halt_req <= h;
        clr_req <= !h;
        @(posedge sys_clk_i);
        halt_req <= 1'b0;
        clr_req <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask : instr
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (5) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rd(ADDR_WATCHDOG_CONTROL, 8'h53);
        rd(ADDR_SYSTEM_CONTROL, 8'h00);
        rd(ADDR_STATUS, 8'h00);
        wr(ADDR_INT_CONTROL, 8'hFF);
        rd(ADDR_INT_CONTROL, 8'h00);
        wr(ADDR_SYSTEM_CONTROL, 8'hFF);
        rd(ADDR_SYSTEM_CONTROL, 8'h80);
        $display("registers done");
        wr(ADDR_WATCHDOG_CONTROL, {KEY_ENABLE, 3'b000});
        instr(0);
        repeat (200) @(posedge sys_clk_i);
        instr(0);
        repeat (240) @(posedge sys_clk_i);
        `CHK("early reset", 1'b0, nrst);
        repeat (30) @(posedge sys_clk_i);
        `CHK("overflow reset", 1, nrst);
        wr(ADDR_WATCHDOG_CONTROL, {KEY_DISABLE, 3'b000});
        rd(ADDR_STATUS, 8'h02);
        repeat (300) @(posedge sys_clk_i);
        `CHK("disabled reset", 1, nrst);
        wr(ADDR_WATCHDOG_CONTROL, 8'h00);
        @(posedge sys_clk_i);
        `CHK("key reset early", 1, nrst);
        repeat (5) @(posedge sys_clk_i);
        `CHK("key reset", 2, nrst);
        wr(ADDR_WATCHDOG_CONTROL, {KEY_DISABLE, 3'b000});
        rd(ADDR_SYSTEM_CONTROL, 8'h81);
        wr(ADDR_SYSTEM_CONTROL, 8'h81);
        rd(ADDR_SYSTEM_CONTROL, 8'h81);
        wr(ADDR_SYSTEM_CONTROL, 8'h00);
        rd(ADDR_SYSTEM_CONTROL, 8'h00);
        $display("watchdog done");
        wr(ADDR_PORTA_WAKE_ENABLE, 8'h01);
        instr(1);
        rd(ADDR_STATUS, 8'h05);
        porta_i <= 8'hFE;
        repeat (5) @(posedge sys_clk_i);
        `CHK("port wake", 1, nres);
        porta_i <= 8'hFF;
        rd(ADDR_STATUS, 8'h01);
        instr(0);
        rd(ADDR_STATUS, 8'h00);
        int_req_i <= 1'b1;
        instr(1);
        repeat (10) @(posedge sys_clk_i);
        `CHK("stale int", 1, nwake);
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk_i);
            int_req_i <= 1'b0;
            int_enabled_i <= (i == 1);
            stack_full_i <= (i == 0);
            if (i == 1) instr(1);
            repeat (2) @(posedge sys_clk_i);
            int_req_i <= 1'b1;
            repeat (5) @(posedge sys_clk_i);
            `CHK("vector", i, nvec);
            `CHK("resume", 2, nres);
        end
        $display("wakeup done");
        int_req_i <= 1'b0;
        wr(ADDR_WATCHDOG_CONTROL, {KEY_ENABLE, 3'b000});
        instr(1);
        repeat (240) @(posedge sys_clk_i);
        `CHK("sleep overflow early", 0, npcsp);
        repeat (40) @(posedge sys_clk_i);
        `CHK("sleep overflow", 1, npcsp);
        rd(ADDR_STATUS, 8'h03);
        $display("sleep overflow done");
        conclude();
    end
endmodule : test_watchdog_and_wakeup
bind watchdog_and_wakeup watchdog_and_wakeup_sva chk (.*);
`default_nettype wire
